// *** inc/irq_unit_consts.vh ***
// Purpose: constants of the two-level interrupt unit
// Assumes: 32-bit wishbone register words, byte addresses
// Notes:   definitions only
`ifndef IRQ_UNIT_CONSTS_VH
`define IRQ_UNIT_CONSTS_VH
// register byte offsets
`define OFS_STATUS        8'h00
`define OFS_SAVED_LOW     8'h04
`define OFS_SAVED_MID     8'h08
`define OFS_LINK_LOW      8'h0C
`define OFS_LINK_MID      8'h10
`define OFS_CAUSE_LOW     8'h14
`define OFS_CAUSE_MID     8'h18
`define OFS_LINE_ENABLE   8'h1C
`define OFS_LEVEL_SELECT  8'h20
`define OFS_LEVEL_TAKEN   8'h24
`define OFS_PENDING       8'h28
`define OFS_SW_TRIGGER    8'h2C
`define OFS_TRIGGER_TYPE  8'h30
`define OFS_PULSE_CANCEL  8'h34
`define OFS_VECTOR_BASE   8'h38
`define OFS_BTA_LOW       8'h3C
`define OFS_BTA_MID       8'h40
`define OFS_BTA           8'h44
// status field positions
`define ST_LOW_EN         1
`define ST_MID_EN         2
`define ST_LOW_ACT        3
`define ST_MID_ACT        4
// flag operand values
`define FLAG_LOW_ONLY     32'h0000_0002
`define FLAG_MID_ONLY     32'h0000_0004
`define FLAG_BOTH         32'h0000_0006
// reset values and other fixed numbers
`define RST_LEVEL_SELECT  32'h0000_0000
`define RST_TRIGGER_TYPE  32'h0000_0000
`define FIRST_IRQ         5'h03
`define LINE_MASK         32'hFFFF_FFF8
`define MEM_ERR_CAUSE     8'h01
`define VECTOR_SHIFT      3
`define LINK_LOW_REG      5'h1D
`define LINK_MID_REG      5'h1E
`endif

// *** rtl/two_level_interrupt_unit.v ***
// Purpose: two-level maskable interrupt unit with wishbone register slave
// Assumes: one core clock, synchronous active-high reset, inputs synchronous
// Notes:   pipeline asks via entry/return strobes; unit answers with vector
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`include "irq_unit_consts.vh"
`default_nettype none
module two_level_interrupt_unit #(
  parameter [31:0] VECTOR_BASE_BUILD = 32'h0000_0000
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // interrupt lines
  input  wire [31:0] irq_i,
  input  wire        mem_err_i,
  // pipeline
  input  wire [31:0] next_pc_i,
  input  wire        hold_compound_i,
  input  wire        hold_limm_i,
  input  wire        hold_pred_branch_i,
  input  wire        hold_flag_i,
  input  wire        flag_i,
  input  wire [31:0] flag_val_i,
  input  wire        jump_restore_low_i,
  input  wire        jump_restore_mid_i,
  input  wire        return_i,
  input  wire        ack_entry_i,
  output reg         take_o,
  output reg  [31:0] vector_addr_o,
  output reg         return_o,
  output reg  [31:0] return_addr_o,
  output reg  [4:0]  return_link_o,
  output reg  [31:0] status_o
);
  reg  [31:0] status_ff;
  reg  [31:0] saved_low_ff;
  reg  [31:0] saved_mid_ff;
  reg  [31:0] link_low_ff;
  reg  [31:0] link_mid_ff;
  reg  [7:0]  cause_low_ff;
  reg  [7:0]  cause_mid_ff;
  reg  [31:0] line_en_ff;
  reg  [31:0] level_sel_ff;
  reg  [1:0]  taken_ff;
  reg  [31:0] trig_type_ff;
  reg  [31:0] pulse_ff;
  reg  [31:0] soft_ff;
  reg  [31:0] vbase_ff;
  reg  [31:0] bta_low_ff;
  reg  [31:0] bta_mid_ff;
  reg  [31:0] bta_ff;
  reg  [31:0] irq_prev_ff;

  // a write lands at the edge at which the master samples ack high
  wire        wr = cyc_i & stb_i & we_i & ack_o;
  // read data is set up a cycle early so that it stands with ack
  wire        rd = cyc_i & stb_i & ~we_i & ~ack_o;
  wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // pending view: level lines live, pulse lines latched, software raises
  wire [31:0] pend = ((irq_i & ~trig_type_ff) | pulse_ff | soft_ff) & `LINE_MASK;
  wire [31:0] cand = pend & line_en_ff;
  wire [31:0] cand_mid = cand & level_sel_ff & {32{status_ff[`ST_MID_EN]}};
  wire [31:0] cand_low = cand & ~level_sel_ff & {32{status_ff[`ST_LOW_EN]}};
  wire        hold = hold_compound_i | hold_limm_i | hold_pred_branch_i | hold_flag_i;

  reg  [4:0]  num_mid;
  reg  [4:0]  num_low;
  integer     i;
  always @* begin
    num_mid = 5'h00;
    num_low = 5'h00;
    for (i = 31; i >= 0; i = i - 1) begin
      if (cand_mid[i]) num_mid = i[4:0];
      if (cand_low[i]) num_low = i[4:0];
    end
  end

  wire        go_mem = mem_err_i & status_ff[`ST_MID_EN];
  wire        go_mid = |cand_mid;
  wire        go_low = |cand_low;
  wire        enter = ~hold & ~take_o & (go_mem | go_mid | go_low);
  wire        enter_mid = go_mem | go_mid;
  wire [7:0]  enter_num = go_mem ? `MEM_ERR_CAUSE :
                          (go_mid ? {3'h0, num_mid} : {3'h0, num_low});
  wire [31:0] enter_bit = (32'h1 << enter_num[4:0]) & {32{~go_mem}};

  // return pair selected by active flags, mid first
  wire        ret_mid = jump_restore_mid_i | (return_i & status_ff[`ST_MID_ACT]);
  wire        ret_low = ~ret_mid & (jump_restore_low_i | (return_i & status_ff[`ST_LOW_ACT]));

  // software trigger number decode, only lines 3..31
  wire [31:0] soft_set = (wr && adr_i == `OFS_SW_TRIGGER && dat_i[4:0] >= `FIRST_IRQ) ?
                         (32'h1 << dat_i[4:0]) : 32'h0;

  // bus handshake: one ack per request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
    end
  end

  // per-line enables
  always @(posedge clk_i) begin
    if (rst_i) begin
      line_en_ff <= 32'h0;
    end else if (wr && adr_i == `OFS_LINE_ENABLE) begin
      line_en_ff <= (line_en_ff & ~wmask) | (dat_i & wmask);
    end
  end

  // level assignment, a set bit puts the line in the level-2 set
  always @(posedge clk_i) begin
    if (rst_i) begin
      level_sel_ff <= `RST_LEVEL_SELECT;
    end else if (wr && adr_i == `OFS_LEVEL_SELECT) begin
      level_sel_ff <= (level_sel_ff & ~wmask) | (dat_i & wmask);
    end
  end

  // sensitivity per line, a set bit makes the line pulse sensitive
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_type_ff <= `RST_TRIGGER_TYPE;
    end else if (wr && adr_i == `OFS_TRIGGER_TYPE) begin
      trig_type_ff <= (trig_type_ff & ~wmask) | (dat_i & wmask);
    end
  end

  // vector base, reloaded from the build value on every reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      vbase_ff <= VECTOR_BASE_BUILD;
    end else if (wr && adr_i == `OFS_VECTOR_BASE) begin
      vbase_ff <= (vbase_ff & ~wmask) | (dat_i & wmask);
    end
  end

  // previous line levels for the pulse edge detector
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_prev_ff <= 32'h0;
    end else begin
      irq_prev_ff <= irq_i;
    end
  end

  // pulse latch: cancel first, new edge and set win, vector call clears
  always @(posedge clk_i) begin
    if (rst_i) begin
      pulse_ff <= 32'h0;
    end else begin
      pulse_ff <= ((pulse_ff &
                    ~((wr && adr_i == `OFS_PULSE_CANCEL) ? (dat_i & wmask) : 32'h0) &
                    ~(enter ? enter_bit : 32'h0)) |
                   (irq_i & ~irq_prev_ff)) & trig_type_ff;
    end
  end

  // software-raised requests, held until their vector is entered
  always @(posedge clk_i) begin
    if (rst_i) begin
      soft_ff <= 32'h0;
    end else begin
      soft_ff <= (soft_ff & ~(enter ? enter_bit : 32'h0)) | soft_set;
    end
  end

  // sticky taken bits: software clears by writing 1, a new entry wins
  always @(posedge clk_i) begin
    if (rst_i) begin
      taken_ff <= 2'h0;
    end else begin
      taken_ff <= (taken_ff &
                   ~((wr && adr_i == `OFS_LEVEL_TAKEN && sel_i[0]) ? dat_i[1:0] : 2'h0)) |
                  (enter ? (enter_mid ? 2'b10 : 2'b01) : 2'b00);
    end
  end

  // status: bus write, then flag operand, then entry or return override
  always @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= 32'h0;
    end else begin
      if (wr && adr_i == `OFS_STATUS) begin
        status_ff <= (status_ff & ~wmask) | (dat_i & wmask);
      end
      if (flag_i) begin
        status_ff[`ST_LOW_EN] <= flag_val_i[`ST_LOW_EN];
        status_ff[`ST_MID_EN] <= flag_val_i[`ST_MID_EN];
      end
      // entry wins over a return in the same cycle
      if (enter && enter_mid) begin
        status_ff[`ST_MID_ACT] <= 1'b1;
        status_ff[`ST_MID_EN]  <= 1'b0;
        status_ff[`ST_LOW_EN]  <= 1'b0;
      end else if (enter) begin
        status_ff[`ST_LOW_ACT] <= 1'b1;
        status_ff[`ST_LOW_EN]  <= 1'b0;
      end else if (ret_mid) begin
        status_ff <= saved_mid_ff;
      end else if (ret_low) begin
        status_ff <= saved_low_ff;
      end
    end
  end

  // level-2 save set: written by software or loaded on a level-2 entry
  always @(posedge clk_i) begin
    if (rst_i) begin
      saved_mid_ff <= 32'h0;
      link_mid_ff  <= 32'h0;
      cause_mid_ff <= 8'h0;
      bta_mid_ff   <= 32'h0;
    end else if (enter && enter_mid) begin
      link_mid_ff  <= next_pc_i;
      saved_mid_ff <= status_ff;
      bta_mid_ff   <= bta_ff;
      cause_mid_ff <= enter_num;
    end else if (wr) begin
      case (adr_i)
        `OFS_SAVED_MID: saved_mid_ff <= (saved_mid_ff & ~wmask) | (dat_i & wmask);
        `OFS_LINK_MID:  link_mid_ff  <= (link_mid_ff & ~wmask) | (dat_i & wmask);
        `OFS_BTA_MID:   bta_mid_ff   <= (bta_mid_ff & ~wmask) | (dat_i & wmask);
        default: ;
      endcase
    end
  end

  // level-1 save set: written by software or loaded on a level-1 entry
  always @(posedge clk_i) begin
    if (rst_i) begin
      saved_low_ff <= 32'h0;
      link_low_ff  <= 32'h0;
      cause_low_ff <= 8'h0;
      bta_low_ff   <= 32'h0;
    end else if (enter && ~enter_mid) begin
      link_low_ff  <= next_pc_i;
      saved_low_ff <= status_ff;
      bta_low_ff   <= bta_ff;
      cause_low_ff <= enter_num;
    end else if (wr) begin
      case (adr_i)
        `OFS_SAVED_LOW: saved_low_ff <= (saved_low_ff & ~wmask) | (dat_i & wmask);
        `OFS_LINK_LOW:  link_low_ff  <= (link_low_ff & ~wmask) | (dat_i & wmask);
        `OFS_BTA_LOW:   bta_low_ff   <= (bta_low_ff & ~wmask) | (dat_i & wmask);
        default: ;
      endcase
    end
  end

  // branch target: software write, restored from the exited level
  // a return in the same cycle as a write keeps the restored value
  always @(posedge clk_i) begin
    if (rst_i) begin
      bta_ff <= 32'h0;
    end else if (~enter && ret_mid) begin
      bta_ff <= bta_mid_ff;
    end else if (~enter && ret_low) begin
      bta_ff <= bta_low_ff;
    end else if (wr && adr_i == `OFS_BTA) begin
      bta_ff <= (bta_ff & ~wmask) | (dat_i & wmask);
    end
  end

  // entry handshake: take stands until the pipeline accepts the vector
  always @(posedge clk_i) begin
    if (rst_i) begin
      take_o        <= 1'b0;
      vector_addr_o <= 32'h0;
    end else if (enter) begin
      take_o        <= 1'b1;
      vector_addr_o <= vbase_ff + ({24'h0, enter_num} << `VECTOR_SHIFT);
    end else if (ack_entry_i) begin
      take_o        <= 1'b0;
    end
  end

  // return strobe: one cycle, with the link value and its core register
  // a return that meets an entry is dropped, the entry goes first
  always @(posedge clk_i) begin
    if (rst_i) begin
      return_o      <= 1'b0;
      return_addr_o <= 32'h0;
      return_link_o <= 5'h0;
    end else if (~enter && ret_mid) begin
      return_o      <= 1'b1;
      return_addr_o <= link_mid_ff;
      return_link_o <= `LINK_MID_REG;
    end else if (~enter && ret_low) begin
      return_o      <= 1'b1;
      return_addr_o <= link_low_ff;
      return_link_o <= `LINK_LOW_REG;
    end else begin
      return_o      <= 1'b0;
    end
  end

  // status copy for the pipeline, one cycle late
  always @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= 32'h0;
    end else begin
      status_o <= status_ff;
    end
  end

  // read mux; write-only and unmapped read zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (rd) begin
      case (adr_i)
        `OFS_STATUS:       dat_o <= status_ff;
        `OFS_SAVED_LOW:    dat_o <= saved_low_ff;
        `OFS_SAVED_MID:    dat_o <= saved_mid_ff;
        `OFS_LINK_LOW:     dat_o <= link_low_ff;
        `OFS_LINK_MID:     dat_o <= link_mid_ff;
        `OFS_CAUSE_LOW:    dat_o <= {24'h0, cause_low_ff};
        `OFS_CAUSE_MID:    dat_o <= {24'h0, cause_mid_ff};
        `OFS_LINE_ENABLE:  dat_o <= line_en_ff;
        `OFS_LEVEL_SELECT: dat_o <= level_sel_ff;
        `OFS_LEVEL_TAKEN:  dat_o <= {30'h0, taken_ff};
        `OFS_PENDING:      dat_o <= pend;
        `OFS_TRIGGER_TYPE: dat_o <= trig_type_ff;
        `OFS_VECTOR_BASE:  dat_o <= vbase_ff;
        `OFS_BTA_LOW:      dat_o <= bta_low_ff;
        `OFS_BTA_MID:      dat_o <= bta_mid_ff;
        `OFS_BTA:          dat_o <= bta_ff;
        default:           dat_o <= 32'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** tb/two_level_interrupt_unit_assertions.sv ***
// Purpose: port assertions of the interrupt unit
// Assumes: status_o lags the status register by one cycle
// Notes:   bound into every unit instance
`include "irq_unit_consts.vh"
`default_nettype none
module irq_unit_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // pipeline side
  input wire logic        flag_i,
  input wire logic [31:0] flag_val_i,
  input wire logic        hold_compound_i,
  input wire logic        hold_limm_i,
  input wire logic        hold_pred_branch_i,
  input wire logic        hold_flag_i,
  input wire logic        return_i,
  input wire logic        ack_entry_i,
  input wire logic        take_o,
  input wire logic [31:0] vector_addr_o,
  input wire logic        return_o,
  input wire logic [4:0]  return_link_o,
  input wire logic [31:0] status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_gate; $rose(take_o) |-> status_o[`ST_LOW_EN] || status_o[`ST_MID_EN]; endproperty
  a_gate: assert property (p_gate) else $error("entry with both enables off");
  property p_act; $rose(take_o) |=> status_o[`ST_LOW_ACT] || status_o[`ST_MID_ACT]; endproperty
  a_act: assert property (p_act) else $error("no active flag after entry");
  property p_low_off; $rose(take_o) |=> !status_o[`ST_LOW_EN]; endproperty
  a_low_off: assert property (p_low_off) else $error("low enable kept on entry");
  property p_flag; flag_i |-> ##2 (status_o & 32'h6) == ($past(flag_val_i, 2) & 32'h6); endproperty
  a_flag: assert property (p_flag) else $error("flag operand not applied");
  property p_ret_link;
    return_o && $past(return_i) |->
      return_link_o == (status_o[`ST_MID_ACT] ? `LINK_MID_REG : `LINK_LOW_REG);
  endproperty
  a_ret_link: assert property (p_ret_link) else $error("wrong link on return");
  property p_hold;
    (hold_compound_i || hold_limm_i || hold_pred_branch_i || hold_flag_i) && !take_o |=> !take_o;
  endproperty
  a_hold: assert property (p_hold) else $error("entry taken during hold");
  property p_stand; take_o && !ack_entry_i |=> take_o && $stable(vector_addr_o); endproperty
  a_stand: assert property (p_stand) else $error("vector not held until accepted");
  property p_clear; take_o && ack_entry_i |=> !take_o; endproperty
  a_clear: assert property (p_clear) else $error("take not cleared after accept");
  property p_ret_pulse; return_o |=> !return_o; endproperty
  a_ret_pulse: assert property (p_ret_pulse) else $error("return strobe too long");
endmodule
bind two_level_interrupt_unit irq_unit_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .flag_i(flag_i), .flag_val_i(flag_val_i), .hold_compound_i(hold_compound_i),
  .hold_limm_i(hold_limm_i), .hold_pred_branch_i(hold_pred_branch_i),
  .hold_flag_i(hold_flag_i), .return_i(return_i), .ack_entry_i(ack_entry_i),
  .take_o(take_o), .vector_addr_o(vector_addr_o), .return_o(return_o),
  .return_link_o(return_link_o), .status_o(status_o));
`default_nettype wire

// *** tb/irq_source_model.sv ***
// Purpose: peripheral requesters on the interrupt lines
// Assumes: bench strobes pulse for one cycle; raise and drop may stay set for many cycles
// Notes:   a released line goes low, its inactive level
`default_nettype none
module irq_source_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // requests from the bench
  input  wire logic [31:0] raise_i,
  input  wire logic [31:0] drop_i,
  input  wire logic [31:0] pulse_i,
  // lines to the unit
  output logic      [31:0] irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] held_ff;
  logic [31:0] pulse_ff;
  // level requesters hold until their routine releases them
  always @(posedge clk_i) begin
    held_ff  <= rst_i ? 32'h0 : (held_ff | raise_i) & ~drop_i;
    pulse_ff <= rst_i ? 32'h0 : pulse_i;
  end
  assign irq_o = held_ff | pulse_ff;
endmodule
`default_nettype wire

// *** tb/tb_two_level_interrupt_unit.sv ***
// Purpose: self-checking bench of the two-level interrupt unit
// Assumes: one-cycle ack, take held until accepted
// Notes:   every scenario starts from a fresh reset
`include "irq_unit_consts.vh"
`default_nettype none
`define CHK(n,e,a) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_two_level_interrupt_unit;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] VB = 32'h0000_0400;
  localparam logic [31:0] PC = 32'h0000_1234;
  logic        clk_i, rst_i, cyc, stb, we, ack, take, ret, flg, aen, rtn, me, jm;
  logic [7:0]  adr;
  logic [3:0]  hold;
  logic [4:0]  rl;
  logic [31:0] dat, rd, rdv, va, ra, st, fv, irq, rz, dz, pz;
  int          err_total, comparisons, cyc_cnt;
  two_level_interrupt_unit #(.VECTOR_BASE_BUILD(VB)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rd),
    .ack_o(ack), .irq_i(irq), .mem_err_i(me), .next_pc_i(PC), .hold_compound_i(hold[0]),
    .hold_limm_i(hold[1]), .hold_pred_branch_i(hold[2]), .hold_flag_i(hold[3]),
    .flag_i(flg), .flag_val_i(fv), .jump_restore_low_i(1'b0), .jump_restore_mid_i(jm),
    .return_i(rtn), .ack_entry_i(aen), .take_o(take), .vector_addr_o(va), .return_o(ret),
    .return_addr_o(ra), .return_link_o(rl), .status_o(st));
  irq_source_model src (.clk_i(clk_i), .rst_i(rst_i), .raise_i(rz), .drop_i(dz),
    .pulse_i(pz), .irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rdv = rd;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rs;
    @(posedge clk_i);
    {rst_i, rz, dz, pz} <= '0 | 97'h1_0000_0000_0000_0000_0000_0000;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic fl(input logic [31:0] v);
    @(posedge clk_i);
    {flg, fv} <= {1'b1, v};
    @(posedge clk_i);
    flg <= 1'b0;
  endtask
  task automatic tk(input logic [31:0] e);
    for (int n = 0; n < 50 && take !== 1'b1; n++) @(posedge clk_i);
    `CHK("vector", e, va)
    aen <= 1'b1;
    @(posedge clk_i);
    aen <= 1'b0;
  endtask
  task automatic s_regs;
    rs();
    wb(0, `OFS_LEVEL_SELECT, 0); `CHK("lvl_sel", `RST_LEVEL_SELECT, rdv)
    wb(0, `OFS_TRIGGER_TYPE, 0); `CHK("trig", `RST_TRIGGER_TYPE, rdv)
    wb(0, `OFS_VECTOR_BASE, 0); `CHK("vbase", VB, rdv)
    wb(1, `OFS_VECTOR_BASE, 32'h800);
    wb(0, `OFS_VECTOR_BASE, 0); `CHK("vbase_wr", 32'h0000_0800, rdv)
    wb(0, 8'h80, 0); `CHK("unmapped", 32'h0, rdv)
    for (logic [31:0] v = 0; v < 8; v += 2) begin
      fl(v);
      wb(0, `OFS_STATUS, 0); `CHK("flag_en", v[2:1], rdv[2:1])
    end
  endtask
  task automatic s_entry;
    rs();
    wb(1, `OFS_LINE_ENABLE, 32'h20);
    fl(6);
    {hold, rz} <= {4'hF, 32'h20};
    repeat (6) @(posedge clk_i);
    `CHK("held", 1'b0, take)
    hold <= 4'h0;
    tk(VB + 32'h28);
    wb(0, `OFS_CAUSE_LOW, 0); `CHK("cause_low", 32'h5, rdv)
    wb(0, `OFS_LINK_LOW, 0); `CHK("link_low", PC, rdv)
    wb(0, `OFS_LEVEL_TAKEN, 0); `CHK("taken", 2'b01, rdv[1:0])
    wb(0, `OFS_STATUS, 0); `CHK("st_entry", 4'b0110, rdv[4:1])
    {rz, dz} <= {32'h0, 32'h20};
    @(posedge clk_i);
    rtn <= 1'b1;
    @(posedge clk_i);
    rtn <= 1'b0;
    @(posedge clk_i);
    `CHK("ret", 1'b1, ret)
    `CHK("ret_addr", PC, ra)
    `CHK("ret_link", `LINK_LOW_REG, rl)
    wb(0, `OFS_STATUS, 0); `CHK("st_exit", 4'b0011, rdv[4:1])
    wb(0, `OFS_CAUSE_LOW, 0); `CHK("cause_kept", 32'h5, rdv)
    wb(1, `OFS_LEVEL_TAKEN, 1);
    wb(0, `OFS_LEVEL_TAKEN, 0); `CHK("taken_clr", 2'b00, rdv[1:0])
  endtask
  task automatic s_prio;
    rs();
    wb(1, `OFS_LINE_ENABLE, 32'h310);
    wb(1, `OFS_LEVEL_SELECT, 32'h200);
    fl(6);
    rz <= 32'h310;
    tk(VB + 32'h48);
    wb(0, `OFS_CAUSE_MID, 0); `CHK("cause_mid", 32'h9, rdv)
    wb(0, `OFS_STATUS, 0); `CHK("st_mid", 2'b00, rdv[2:1])
    fl(2);
    tk(VB + 32'h20);
  endtask
  task automatic s_pulse;
    rs();
    wb(1, `OFS_TRIGGER_TYPE, 32'h40);
    {rz, pz} <= {32'h20, 32'h40};
    @(posedge clk_i);
    {rz, pz} <= 64'h0;
    repeat (3) @(posedge clk_i);
    wb(0, `OFS_PENDING, 0); `CHK("pend", 2'b11, rdv[6:5])
    wb(1, `OFS_PULSE_CANCEL, 32'h60);
    wb(0, `OFS_PENDING, 0); `CHK("pend_cxl", 2'b01, rdv[6:5])
    wb(1, `OFS_SW_TRIGGER, 32'h7);
    wb(1, `OFS_LINE_ENABLE, 32'h80);
    fl(2);
    tk(VB + 32'h38);
  endtask
  task automatic s_mem;
    rs();
    fl(6);
    me <= 1'b1;
    tk(VB + 32'h8);
    me <= 1'b0;
    wb(0, `OFS_CAUSE_MID, 0); `CHK("cause_mem", 32'h1, rdv)
    jm <= 1'b1;
    @(posedge clk_i);
    jm <= 1'b0;
    @(posedge clk_i);
    `CHK("jret", 1'b1, ret)
    `CHK("jret_link", `LINK_MID_REG, rl)
    wb(0, `OFS_STATUS, 0); `CHK("st_jret", 4'b0011, rdv[4:1])
  endtask
  initial begin
    {rst_i, cyc, stb, we, adr, dat, flg, fv, rtn, aen, hold, me, jm} = '0;
    rst_i = 1'b1;
    {rz, dz, pz} = '0;
    {err_total, comparisons, cyc_cnt} = '0;
    s_regs();
    s_entry();
    s_prio();
    s_pulse();
    s_mem();
    end_sim();
  end
endmodule
`default_nettype wire
